// File: common/scmc_pkg.sv
// constants shared by the system clock mode control block
package scmc_pkg;
    // processor mode register layout and reset pattern 01001000
    localparam logic [7:0] MODE_REG_RST    = 8'h48;
    localparam int         MODE_SEL_LSB    = 6;
    localparam int         MAIN_STOP_BIT   = 5;
    localparam int         SUB_OSC_BIT     = 4;
    // frequency mode codes in the mode select field
    typedef enum logic [1:0] {
        SCMC_HIGH   = 2'b00,
        SCMC_MIDDLE = 2'b01,
        SCMC_LOW    = 2'b10,
        SCMC_RSVD   = 2'b11
    } scmc_mode_e;
    // oscillator edges per half period of the internal clock
    localparam logic [2:0] MIDDLE_HALF_EDGES = 3'h4;
    localparam logic [2:0] HIGH_HALF_EDGES   = 3'h1;
    localparam logic [2:0] LOW_HALF_EDGES    = 3'h1;
endpackage

// File: hw/scmc_edge.sv
// two-stage synchroniser with rising-edge pulse for an oscillator pin
`timescale 1ns/1ps
`default_nettype none
module scmc_edge (
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_b_in,
    // pin and pulse
    input  wire logic pin_in,
    output logic      rise_out
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign rise_out = sync_ff & ~last_ff;
endmodule
`default_nettype wire

// File: hw/scmc_top.sv
// system clock mode control: oscillator gating, mode select and internal clock divider
`timescale 1ns/1ps
`default_nettype none
// Operation
// RQ1: two oscillators, main on main pin pair, sub on sub pin pair.
// RQ2: after power-up only main oscillator runs; sub pins act as ports.
// RQ3: middle-speed mode gives internal clock of main oscillator divided by eight.
// RQ4: reset selects middle-speed mode.
// RQ5: high-speed mode gives internal clock of main oscillator divided by two.
// RQ6: low-speed mode gives internal clock of sub oscillator divided by two.
// RQ7: software makes both oscillators stable before main/low mode changes.
// RQ8: main frequency must exceed three times sub frequency when switching.
// RQ9: in low-speed mode, main stop bit set stops the main oscillator.
// RQ10: clearing main stop bit restarts main oscillator; software waits to settle.
// RQ11: mode register resets to 01001000, main stop bit clear.
// RQ12: stop instruction parks internal clock high and stops both oscillators.
// RQ13: source and ratio changes are glitch-free, no short clock pulse.
module scmc_top (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    // oscillator pins
    input  wire logic       main_osc_in,
    input  wire logic       sub_osc_in,
    output logic            main_osc_out,
    output logic            sub_osc_out,
    output logic            sub_port_mode_out,
    // processor mode register access
    input  wire logic       mode_wr_in,
    input  wire logic [7:0] mode_wdata_in,
    output logic [7:0]      processor_mode_reg_out,
    // stop instruction and release
    input  wire logic       stop_instruction_in,
    input  wire logic       wake_in,
    output logic            stopped_out,
    // internal clock
    output logic            phi_out,
    output logic            phi_rise_out,
    output logic [1:0]      active_mode_out
);
    // =====================================================
    // oscillator edge detection
    logic main_rise;
    logic sub_rise;

    scmc_edge u_main_edge (                                     // RQ1
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .pin_in     (main_osc_in),
        .rise_out   (main_rise)
    );

    scmc_edge u_sub_edge (                                      // RQ1
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .pin_in     (sub_osc_in),
        .rise_out   (sub_rise)
    );

    // =====================================================
    // processor mode register
    logic [7:0] mode_reg_ff;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_reg_ff <= scmc_pkg::MODE_REG_RST;              // RQ11 RQ4
        end else if (mode_wr_in) begin
            mode_reg_ff <= mode_wdata_in;
        end
    end

    logic [1:0] req_mode;
    assign req_mode = mode_reg_ff[scmc_pkg::MODE_SEL_LSB +: 2];

    // =====================================================
    // internal clock divider
    scmc_pkg::scmc_mode_e act_mode_ff;
    scmc_pkg::scmc_mode_e want_mode;
    logic                 mode_held;
    logic [2:0]           edge_cnt_ff;
    logic                 phi_ff;
    logic                 stop_pend_ff;
    logic                 stopped_ff;
    logic                 act_low;
    logic                 src_edge;
    logic [2:0]           half_edges;
    logic                 toggle;

    assign act_low  = (act_mode_ff == scmc_pkg::SCMC_LOW);
    assign src_edge = stopped_ff ? 1'b0 : (act_low ? sub_rise : main_rise);   // RQ6

    always_comb begin
        unique case (act_mode_ff)
            scmc_pkg::SCMC_HIGH: half_edges = scmc_pkg::HIGH_HALF_EDGES;      // RQ5
            scmc_pkg::SCMC_LOW:  half_edges = scmc_pkg::LOW_HALF_EDGES;       // RQ6
            default:             half_edges = scmc_pkg::MIDDLE_HALF_EDGES;    // RQ3
        endcase
    end

    assign toggle = src_edge && (edge_cnt_ff + 3'h1 >= half_edges);

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            edge_cnt_ff <= 3'h0;
        end else if (toggle) begin
            edge_cnt_ff <= 3'h0;
        end else if (src_edge) begin
            edge_cnt_ff <= edge_cnt_ff + 3'h1;
        end
    end

    // =====================================================
    // frequency mode selection
    // reserved code falls back to middle speed
    always_comb begin
        unique case (req_mode)
            scmc_pkg::SCMC_HIGH: want_mode = scmc_pkg::SCMC_HIGH;
            scmc_pkg::SCMC_LOW:  want_mode = scmc_pkg::SCMC_LOW;
            default:             want_mode = scmc_pkg::SCMC_MIDDLE;
        endcase
    end

    // never switch onto a source that is not running:
    // main modes wait while main is stopped, low waits while sub is off
    assign mode_held = (want_mode == scmc_pkg::SCMC_LOW) ?
                       !mode_reg_ff[scmc_pkg::SUB_OSC_BIT] :
                       mode_reg_ff[scmc_pkg::MAIN_STOP_BIT];             // RQ9

    // new mode is taken only at a half-period boundary, so every
    // half period is made whole from one source and one ratio
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            act_mode_ff <= scmc_pkg::SCMC_MIDDLE;               // RQ4
        end else if (toggle && !mode_held) begin
            act_mode_ff <= want_mode;                           // RQ13
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phi_ff <= 1'b0;
        end else if (toggle) begin
            phi_ff <= ~phi_ff;                                  // RQ13
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phi_rise_out <= 1'b0;
        end else begin
            phi_rise_out <= toggle & ~phi_ff;
        end
    end

    // =====================================================
    // stop mode: waits for clock high, then parks it there
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stop_pend_ff <= 1'b0;
            stopped_ff   <= 1'b0;
        end else if (stop_pend_ff && (toggle ? ~phi_ff : phi_ff)) begin
            stop_pend_ff <= 1'b0;
            stopped_ff   <= 1'b1;                               // RQ12
        end else if (stop_instruction_in && !stopped_ff) begin
            stop_pend_ff <= 1'b1;
        end else if (wake_in) begin
            // setting events win over a wake in the same cycle
            stop_pend_ff <= 1'b0;
            stopped_ff   <= 1'b0;
        end
    end

    // =====================================================
    // oscillator enables and outputs
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            main_osc_out <= 1'b1;                               // RQ2
        end else begin
            main_osc_out <= !stopped_ff &&
                            !(act_low && mode_reg_ff[scmc_pkg::MAIN_STOP_BIT]);  // RQ9 RQ10
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sub_osc_out <= 1'b0;                                // RQ2
        end else begin
            sub_osc_out <= !stopped_ff && mode_reg_ff[scmc_pkg::SUB_OSC_BIT];    // RQ12
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sub_port_mode_out <= 1'b1;                          // RQ2
        end else begin
            sub_port_mode_out <= !mode_reg_ff[scmc_pkg::SUB_OSC_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            processor_mode_reg_out <= scmc_pkg::MODE_REG_RST;   // RQ11
        end else begin
            processor_mode_reg_out <= mode_reg_ff;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stopped_out <= 1'b0;
        end else begin
            stopped_out <= stopped_ff;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phi_out <= 1'b0;
        end else begin
            phi_out <= phi_ff;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            active_mode_out <= scmc_pkg::SCMC_MIDDLE;           // RQ4
        end else begin
            active_mode_out <= act_mode_ff;
        end
    end
endmodule
`default_nettype wire

// File: sim/scmc_top_sva.sv
// assertions for the system clock mode control block
`timescale 1ns/1ps
`default_nettype none
module scmc_top_sva (
    // clock and reset
    input wire logic       ref_clk_in,
    input wire logic       rst_b_in,
    // watched ports
    input wire logic       mode_wr_in,
    input wire logic [7:0] mode_wdata_in,
    input wire logic [7:0] processor_mode_reg_out,
    input wire logic       main_osc_out,
    input wire logic       sub_osc_out,
    input wire logic       sub_port_mode_out,
    input wire logic       stopped_out,
    input wire logic       phi_out,
    input wire logic       phi_rise_out,
    input wire logic [1:0] active_mode_out
);
    // ==========================================================
    // checks
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    // cycles since the last phi change, saturating
    logic [1:0] gap_ff;
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) gap_ff <= 2'h3;
        else if ($changed(phi_out)) gap_ff <= 2'h0;
        else if (gap_ff != 2'h3) gap_ff <= gap_ff + 2'h1;
    end
    chk_reset_vals: assert property ($rose(rst_b_in) |-> active_mode_out == 2'h1
        && processor_mode_reg_out == 8'h48 && main_osc_out) else $error("reset state wrong");
    chk_wr_latency: assert property ($past(mode_wr_in, 2)
        |-> processor_mode_reg_out == $past(mode_wdata_in, 2)) else $error("readback wrong");
    chk_reg_hold: assert property (!$past(mode_wr_in, 2)
        |-> $stable(processor_mode_reg_out)) else $error("register changed unasked");
    chk_rise_pulse: assert property ($rose(phi_out) == $past(phi_rise_out))
        else $error("rise pulse misplaced");
    chk_stop_high: assert property (stopped_out |-> phi_out) else $error("stop not high");
    chk_stop_osc: assert property (stopped_out |-> !main_osc_out && !sub_osc_out)
        else $error("oscillator runs in stop");
    chk_sub_port: assert property (!stopped_out |-> sub_port_mode_out
        != processor_mode_reg_out[scmc_pkg::SUB_OSC_BIT]) else $error("sub port mode wrong");
    chk_main_run: assert property (!stopped_out && (active_mode_out != 2'h2
        || !processor_mode_reg_out[5]) |-> main_osc_out) else $error("main stopped wrongly");
    chk_no_glitch: assert property ($changed(phi_out) |-> gap_ff != 2'h0)
        else $error("short phi pulse");
    cov_stop: cover property (stopped_out);
    cov_high: cover property (active_mode_out == 2'h0);
    cov_main_off: cover property (active_mode_out == 2'h2 && !main_osc_out);
endmodule
`default_nettype wire

// File: sim/scmc_top_tb_top.sv
// self-checking bench for the system clock mode control block
`timescale 1ns/1ps
`default_nettype none
module scmc_top_tb_top;
    logic       ref_clk_in, rst_b_in, main_osc_in, sub_osc_in, mode_wr_in;
    logic       stop_instruction_in, wake_in, main_osc_out, sub_osc_out;
    logic       sub_port_mode_out, stopped_out, phi_out, phi_rise_out;
    logic [7:0] mode_wdata_in, processor_mode_reg_out;
    logic [1:0] active_mode_out;
    int         num_errors, samples_checked, cyc;
    scmc_top dut_u (
        .ref_clk_in             (ref_clk_in),
        .rst_b_in               (rst_b_in),
        .main_osc_in            (main_osc_in),
        .sub_osc_in             (sub_osc_in),
        .main_osc_out           (main_osc_out),
        .sub_osc_out            (sub_osc_out),
        .sub_port_mode_out      (sub_port_mode_out),
        .mode_wr_in             (mode_wr_in),
        .mode_wdata_in          (mode_wdata_in),
        .processor_mode_reg_out (processor_mode_reg_out),
        .stop_instruction_in    (stop_instruction_in),
        .wake_in                (wake_in),
        .stopped_out            (stopped_out),
        .phi_out                (phi_out),
        .phi_rise_out           (phi_rise_out),
        .active_mode_out        (active_mode_out)
    );
    // ==========================================================
    // clock, oscillator pins and timeout
    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end
    always @(negedge ref_clk_in) begin
        cyc++;
        if (main_osc_out && cyc % 2 == 0) main_osc_in <= ~main_osc_in;
        if (sub_osc_out && cyc % 8 == 0) sub_osc_in <= ~sub_osc_in;
        if (cyc > 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    // ==========================================================
    // helpers
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp, input string m);
        samples_checked++;
        if (got < exp - 1 || got > exp + 1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task automatic wr(input logic [7:0] d);
        @(negedge ref_clk_in);
        mode_wr_in = 1'b1;
        mode_wdata_in = d;
        @(negedge ref_clk_in);
        mode_wr_in = 1'b0;
        wait_n(3);
    endtask
    task automatic rises(output int n);
        n = 0;
        repeat (640) @(negedge ref_clk_in) if (phi_rise_out === 1'b1) n++;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_rates;
        logic [7:0] d [4] = '{8'h50, 8'h10, 8'h90, 8'hD0};
        logic [1:0] m [4] = '{2'h1, 2'h0, 2'h2, 2'h1};
        int         e [4] = '{20, 80, 20, 20};
        int         n;
        for (int i = 0; i < 4; i++) begin
            wr(d[i]);
            wait_n(80);
            rises(n);
            chk_cnt(n, e[i], "phi rate");
            chk_val({6'h0, active_mode_out}, {6'h0, m[i]}, "mode");
        end
        chk_val({6'h0, sub_osc_out, sub_port_mode_out}, 8'h02, "sub pins");
        $display("test rates done");
    endtask
    task automatic t_main_stop;
        int n;
        wr(8'h90);
        wait_n(80);
        wr(8'hB0);
        chk_val({7'h0, main_osc_out}, 8'h00, "main not stopped");
        wr(8'h30);
        wait_n(80);
        rises(n);
        chk_cnt(n, 20, "low rate");
        chk_val({6'h0, active_mode_out}, 8'h02, "mode left low");
        wr(8'h90);
        chk_val({7'h0, main_osc_out}, 8'h01, "main not restarted");
        wait_n(80);
        wr(8'h10);
        wait_n(80);
        chk_val({6'h0, active_mode_out}, 8'h00, "high not entered");
        $display("test main stop done");
    endtask
    task automatic t_stop;
        int n;
        @(negedge ref_clk_in) stop_instruction_in = 1'b1;
        @(negedge ref_clk_in) stop_instruction_in = 1'b0;
        for (int i = 0; i < 200 && stopped_out !== 1'b1; i++) wait_n(1);
        chk_val({5'h0, stopped_out, phi_out, main_osc_out | sub_osc_out}, 8'h06, "stop");
        rises(n);
        chk_val(n[7:0], 8'h00, "phi runs in stop");
        @(negedge ref_clk_in) wake_in = 1'b1;
        @(negedge ref_clk_in) wake_in = 1'b0;
        wait_n(80);
        rises(n);
        chk_cnt(n, 80, "no resume");
        $display("test stop done");
    endtask
    initial begin
        {rst_b_in, main_osc_in, sub_osc_in, mode_wr_in, stop_instruction_in, wake_in} = '0;
        mode_wdata_in = 8'h00;
        wait_n(2);
        rst_b_in = 1'b1;
        wait_n(20);
        chk_val(processor_mode_reg_out, 8'h48, "reset pattern");
        chk_val({3'h0, active_mode_out, main_osc_out, sub_osc_out, sub_port_mode_out},
                8'h0D, "reset modes");
        $display("test reset done");
        t_rates();
        t_main_stop();
        t_stop();
        give_verdict();
    end
endmodule
bind scmc_top scmc_top_sva chk_u (
    .ref_clk_in             (ref_clk_in),
    .rst_b_in               (rst_b_in),
    .mode_wr_in             (mode_wr_in),
    .mode_wdata_in          (mode_wdata_in),
    .processor_mode_reg_out (processor_mode_reg_out),
    .main_osc_out           (main_osc_out),
    .sub_osc_out            (sub_osc_out),
    .sub_port_mode_out      (sub_port_mode_out),
    .stopped_out            (stopped_out),
    .phi_out                (phi_out),
    .phi_rise_out           (phi_rise_out),
    .active_mode_out        (active_mode_out)
);
`default_nettype wire
